// File: can_guard_pkg.sv
package can_guard_pkg;

  localparam int unsigned clk_hz = 10_000_000;
  // dominant timeout window, in microseconds
  localparam int unsigned timeout_min_us = 1200;
  localparam int unsigned timeout_max_us = 3800;
  // chosen terminal point inside the window
  localparam int unsigned timeout_nom_us = 2500;
  localparam int unsigned timeout_cycles = timeout_nom_us * (clk_hz / 1_000_000);
  // undervoltage re-enable delay, microseconds (longest time: round down)
  localparam int unsigned uv_reenable_us = 300;
  localparam int unsigned uv_reenable_cycles = uv_reenable_us * (clk_hz / 1_000_000);
  localparam int unsigned fifo_depth = 32;
  localparam logic level_dominant = 1'b0;
  localparam logic level_recessive = 1'b1;

  typedef enum logic [1:0] {
    drv_normal,
    drv_timed_out,
    drv_thermal,
    drv_undervolt
  } drv_state_type;

endpackage : can_guard_pkg

// File: tx_fifo_if.sv
`timescale 1ns/100ps
`default_nettype none
interface tx_fifo_if #(parameter int width = 1);
  logic in_valid;
  logic in_ready;
  logic [width-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [width-1:0] out_data;
  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : tx_fifo_if
`default_nettype wire

// File: sample_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module sample_fifo #(
  parameter int width = 1,
  parameter int depth = 32
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // stream
  tx_fifo_if.fifo port
);
  localparam int aw = $clog2(depth);
  logic [width-1:0] mem_reg [depth];
  logic [aw-1:0] wr_ptr_reg;
  logic [aw-1:0] rd_ptr_reg;
  logic [aw:0] count_reg;
  logic do_wr;
  logic do_rd;

  assign port.in_ready = (count_reg != (aw+1)'(depth));
  assign port.out_valid = (count_reg != '0);
  assign port.out_data = mem_reg[rd_ptr_reg];
  assign do_wr = port.in_valid && port.in_ready;
  assign do_rd = port.out_valid && port.out_ready;

  always_ff @(posedge clk_sys)
  begin
    if (do_wr)
      mem_reg[wr_ptr_reg] <= port.in_data;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (do_wr)
        wr_ptr_reg <= (wr_ptr_reg == aw'(depth - 1)) ? '0 : wr_ptr_reg + 1'b1;
      if (do_rd)
        rd_ptr_reg <= (rd_ptr_reg == aw'(depth - 1)) ? '0 : rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (aw+1)'(do_wr) - (aw+1)'(do_rd);
    end
  end
endmodule : sample_fifo
`default_nettype wire

// File: can_phy_dominant_timeout_guard.sv
// Overview of operation
// [R1] bus driven differentially is dominant (low); merely biased bus is recessive (high)
// [R2] host transmits on tx input, reads bus data on rx output; low means dominant
// [R3] undriven tx input reads recessive through a weak pull-up
// [R4] dominant-timeout timer restarts on every tx falling edge
// [R5] no rising edge before timeout expiry disables the driver, freeing the bus
// [R6] tx returning high re-enables the driver and clears the timeout
// [R7] during timeout bus stays recessive, rx output still follows the bus
// [R8] host never sends over 11 dominant bits; bit rate at least 11/min timeout
// [R9] over-temperature turns driver off, bus recessive, receive path still works
// [R10] thermal shutdown ends only when the over-temperature indication clears
// [R11] rx low at 900 mV differential or more, high at 500 mV or less, open
// [R12] timeout period lies between 1.2 ms and 3.8 ms from tx falling edge
// [R13] bus-side undervoltage disables transceiver, bus high impedance, rx high
// [R14] after undervoltage clears, normal operation resumes within 300 us
// [R15] timeout is a free-running-clock counter reset on each tx falling edge
`timescale 1ns/100ps
`default_nettype none
module can_phy_dominant_timeout_guard
  import can_guard_pkg::*;
#(
  parameter int unsigned timeout_count = can_guard_pkg::timeout_cycles,
  parameter int unsigned uv_count = can_guard_pkg::uv_reenable_cycles,
  parameter int fifo_words = can_guard_pkg::fifo_depth
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // host side pins
  input wire logic tx_in,
  input wire logic tx_in_oe,
  output logic rx_out,
  // bus side, digitised comparator results and driver controls
  input wire logic bus_diff_high,
  input wire logic bus_diff_low,
  input wire logic bus_open,
  output logic bus_drive_dominant,
  output logic bus_bias_recessive,
  // supply and temperature indications
  input wire logic thermal_shutdown,
  input wire logic bus_side_supply_low,
  // status
  output logic dominant_timeout,
  output logic driver_enabled
);
  import can_guard_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  localparam int nsync = 6;
  // tx resets to its idle level, so releasing reset makes no false falling edge
  localparam logic [nsync-1:0] sync_idle = {level_recessive, {(nsync-1){1'b0}}};
  logic [nsync-1:0] sync1_reg;
  logic [nsync-1:0] sync2_reg;
  logic [nsync-1:0] raw_in;
  logic tx_s, diff_hi_s, diff_lo_s, open_s, therm_s, uvlo_s;

  // undriven tx reads recessive through the weak pull-up  [R3]
  assign raw_in = {tx_in_oe ? tx_in : level_recessive, bus_diff_high, bus_diff_low, bus_open,
                   thermal_shutdown, bus_side_supply_low};

  genvar gi;
  generate
    for (gi = 0; gi < nsync; gi++)
    begin : g_sync
      always_ff @(posedge clk_sys or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          sync1_reg[gi] <= sync_idle[gi];
          sync2_reg[gi] <= sync_idle[gi];
        end
        else
        begin
          sync1_reg[gi] <= raw_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  assign {tx_s, diff_hi_s, diff_lo_s, open_s, therm_s, uvlo_s} = sync2_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // tx sample path through the fifo; output side never stalls,
  // so the queue holds one word and only adds a cycle of latency
  tx_fifo_if #(.width(1)) txq ();
  logic tx_q_reg;
  logic tx_prev_reg;
  logic tx_fall;
  logic tx_rise;

  assign txq.in_valid = 1'b1;
  assign txq.in_data = tx_s;
  assign txq.out_ready = 1'b1;

  sample_fifo #(.width(1), .depth(fifo_words)) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .port(txq)
  );

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_q_reg <= level_recessive;
      tx_prev_reg <= level_recessive;
    end
    else
    begin
      if (txq.out_valid)
        tx_q_reg <= txq.out_data[0];
      tx_prev_reg <= tx_q_reg;
    end
  end

  assign tx_fall = tx_prev_reg && !tx_q_reg;
  assign tx_rise = !tx_prev_reg && tx_q_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // dominant timeout counter
  logic [31:0] dto_cnt_reg;
  logic dto_expired;

  // counter restarts at each falling edge; terminal count sits inside the window  [R15] [R4] [R12]
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      dto_cnt_reg <= '0;
    else if (tx_fall || tx_q_reg)
      dto_cnt_reg <= '0;
    else if (dto_cnt_reg != timeout_count)
      dto_cnt_reg <= dto_cnt_reg + 32'h1;
  end

  assign dto_expired = (dto_cnt_reg == timeout_count) && !tx_q_reg && !tx_rise; // [R5]

  ////////////////////////////////////////////////////////////////////////////////
  // undervoltage re-enable delay
  logic [31:0] uv_cnt_reg;
  logic uv_active;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      uv_cnt_reg <= '0;
    else if (uvlo_s)
      uv_cnt_reg <= uv_count; // [R13]
    else if (uv_cnt_reg != '0)
      uv_cnt_reg <= uv_cnt_reg - 32'h1; // [R14]
  end

  assign uv_active = uvlo_s || (uv_cnt_reg != '0);

  ////////////////////////////////////////////////////////////////////////////////
  // driver state machine; undervoltage outranks thermal, thermal outranks timeout
  drv_state_type state_reg;
  drv_state_type state_next;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      drv_normal:
        if (dto_expired)
          state_next = drv_timed_out; // [R5]
      drv_timed_out:
        if (tx_q_reg)
          state_next = drv_normal; // [R6]
      // an expired hold goes straight to timeout, avoiding a one-cycle dominant glitch
      drv_thermal:
        if (!therm_s)
          state_next = dto_expired ? drv_timed_out : drv_normal; // [R10]
      drv_undervolt:
        if (!uv_active)
          state_next = dto_expired ? drv_timed_out : drv_normal; // [R14]
    endcase
    if (uv_active)
      state_next = drv_undervolt; // [R13]
    else if (therm_s)
      state_next = drv_thermal; // [R9]
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      state_reg <= drv_normal;
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bus_drive_dominant <= 1'b0;
      bus_bias_recessive <= 1'b1;
      rx_out <= level_recessive;
      dominant_timeout <= 1'b0;
      driver_enabled <= 1'b0;
    end
    else
    begin
      // low on tx drives dominant only in normal state  [R1] [R2] [R7] [R9]
      bus_drive_dominant <= (state_next == drv_normal) && (tx_q_reg == level_dominant);
      // bias drops to high impedance in undervoltage  [R13]
      bus_bias_recessive <= (state_next != drv_undervolt);
      // receive path: the analog threshold gap holds the last rx level  [R11] [R7] [R9]
      if (state_next == drv_undervolt)
        rx_out <= level_recessive; // [R13]
      else if (open_s)
        rx_out <= level_recessive; // [R11]
      else if (diff_hi_s)
        rx_out <= level_dominant; // [R11]
      else if (diff_lo_s)
        rx_out <= level_recessive; // [R11]
      dominant_timeout <= (state_next == drv_timed_out);
      driver_enabled <= (state_next == drv_normal);
    end
  end
endmodule : can_phy_dominant_timeout_guard
`default_nettype wire

// File: can_guard_props.sv
`timescale 1ns/100ps
`default_nettype none
module can_guard_props #(
  parameter int unsigned timeout_count = 50,
  parameter int unsigned uv_count = 20
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // host side
  input wire logic tx_in,
  input wire logic tx_in_oe,
  input wire logic rx_out,
  // bus side
  input wire logic bus_diff_high,
  input wire logic bus_drive_dominant,
  input wire logic bus_bias_recessive,
  // faults and status
  input wire logic thermal_shutdown,
  input wire logic bus_side_supply_low,
  input wire logic dominant_timeout,
  input wire logic driver_enabled
);
  localparam int uv_lim = uv_count + 8;
  logic lo;
  logic lo_d;
  logic [15:0] qcnt;
  assign lo = tx_in_oe && !tx_in;
  always_ff @(posedge clk_sys)
    lo_d <= lo;
  // age of a dominant hold from its fall; a fault zeroes it so a resumed hold is not judged
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      qcnt <= 16'h0;
    else if (!lo || thermal_shutdown || bus_side_supply_low)
      qcnt <= 16'h0;
    else if (qcnt != 16'h0 || !lo_d)
      qcnt <= qcnt + 16'h1;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  a_drive_dominant:
    assert property ((lo && driver_enabled && !dominant_timeout && qcnt < timeout_count && !thermal_shutdown
      && !bus_side_supply_low)[*6] |-> bus_drive_dominant) else $error("no dominant");
  a_timeout_early:
    assert property ($rose(dominant_timeout) |-> qcnt == 16'h0 || qcnt >= timeout_count) else $error("early");
  a_timeout_late:
    assert property (qcnt == timeout_count + 8 |-> dominant_timeout && !bus_drive_dominant) else $error("late");
  a_timeout_bias:
    assert property (dominant_timeout[*2] |-> bus_bias_recessive && !bus_drive_dominant) else $error("bias");
  a_thermal_off:
    assert property ((thermal_shutdown && !bus_side_supply_low)[*4] |-> !bus_drive_dominant && bus_bias_recessive)
      else $error("thermal");
  a_uv_off:
    assert property (bus_side_supply_low[*4] |-> !bus_drive_dominant && !bus_bias_recessive && rx_out
      && !driver_enabled) else $error("uv");
  a_uv_resume:
    assert property ($fell(bus_side_supply_low) && !thermal_shutdown |-> (!driver_enabled)[*8] ##[1:uv_lim]
      driver_enabled) else $error("resume");
  a_rx_dominant:
    assert property ((bus_diff_high && !bus_side_supply_low)[*4] |-> !rx_out) else $error("rx");
endmodule : can_guard_props
bind can_phy_dominant_timeout_guard can_guard_props #(.timeout_count(timeout_count), .uv_count(uv_count))
  u_props (.clk_sys(clk_sys), .sys_rst(sys_rst), .tx_in(tx_in), .tx_in_oe(tx_in_oe), .rx_out(rx_out),
  .bus_diff_high(bus_diff_high), .bus_drive_dominant(bus_drive_dominant),
  .bus_bias_recessive(bus_bias_recessive), .thermal_shutdown(thermal_shutdown),
  .bus_side_supply_low(bus_side_supply_low), .dominant_timeout(dominant_timeout),
  .driver_enabled(driver_enabled));
`default_nettype wire

// File: can_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module can_host_model (
  // clock
  input wire logic clk_sys,
  // commands
  input wire logic go,
  input wire logic stuck,
  input wire logic [15:0] data,
  // pins
  output logic tx_in,
  output logic tx_in_oe,
  output logic busy
);
  logic s, g;
  int run;
  task automatic put(input logic b);
    tx_in = b;
    run = b ? 0 : run + 1;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : put
  initial
  begin
    {tx_in, tx_in_oe, busy} = 3'h0;
    forever
    begin
      @(posedge clk_sys);
      {s, g} = {stuck, go};
      #1;
      if (s)
        {tx_in_oe, tx_in} = 2'h2;
      else if (g)
      begin
        busy = 1'b1;
        tx_in_oe = 1'b1;
        for (int n = 15; n >= 0; n--)
        begin
          // stuffed recessive bit keeps dominant runs far below eleven bits
          if (run == 5)
            put(1'b1);
          put(data[n]);
        end
        put(1'b1);
        {tx_in_oe, tx_in, busy} = 3'h0;
      end
      else if (tx_in_oe && !tx_in)
        tx_in = 1'b1;
      else
        {tx_in_oe, tx_in} = 2'h0;
    end
  end
endmodule : can_host_model
`default_nettype wire

// File: can_phy_dominant_timeout_guard_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module can_phy_dominant_timeout_guard_tb_top;
  localparam int unsigned tc = 50;
  localparam int unsigned uc = 20;
  logic clk_sys, sys_rst, tx_in, tx_in_oe, rx_out, bus_diff_high, bus_diff_low, bus_open;
  logic bus_drive_dominant, bus_bias_recessive, thermal_shutdown, bus_side_supply_low;
  logic dominant_timeout, driver_enabled, go, stuck, busy, loop, e;
  logic [15:0] data;
  logic [1:0] lb_pair, set_pair;
  logic [4:0] st;
  logic [2:0] pat [5] = '{3'h0, 3'h1, 3'h4, 3'h0, 3'h2};
  int errors, checked;
  assign st = {dominant_timeout, bus_drive_dominant, bus_bias_recessive, rx_out, driver_enabled};
  can_host_model host (.clk_sys(clk_sys), .go(go), .stuck(stuck), .data(data), .tx_in(tx_in),
    .tx_in_oe(tx_in_oe), .busy(busy));
  can_phy_dominant_timeout_guard #(.timeout_count(tc), .uv_count(uc)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .tx_in(tx_in), .tx_in_oe(tx_in_oe), .rx_out(rx_out), .bus_diff_high(bus_diff_high),
    .bus_diff_low(bus_diff_low), .bus_open(bus_open), .bus_drive_dominant(bus_drive_dominant),
    .bus_bias_recessive(bus_bias_recessive), .thermal_shutdown(thermal_shutdown),
    .bus_side_supply_low(bus_side_supply_low), .dominant_timeout(dominant_timeout),
    .driver_enabled(driver_enabled));
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // bus loopback while frames run
  // one driver per comparator pin: loopback or the scenario's own levels
  always @(posedge clk_sys)
    lb_pair <= #2 {bus_drive_dominant, !bus_drive_dominant};
  assign {bus_diff_high, bus_diff_low} = loop ? lb_pair : set_pair;
  ////////////////////////////////////////
  function automatic logic exp_rx(input logic [2:0] b, input logic prev);
    return b[2] ? 1'b0 : (b[1] || b[0]) ? 1'b1 : prev;
  endfunction : exp_rx
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : cyc
  task automatic chk(input string name, input logic [4:0] exp, input logic [4:0] got);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic frame();
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    for (int k = 0; k < 200 && busy; k++)
      cyc(1);
    chk("busy", 5'h0, {4'h0, busy});
  endtask : frame
  initial
  begin
    #1_000_000;
    errors++;
    report_and_stop();
  end
  initial
  begin
    void'($urandom(29));
    {sys_rst, go, stuck, loop, data} = {4'h9, 16'h0};
    {set_pair, bus_open, thermal_shutdown, bus_side_supply_low} = 5'h0;
    cyc(12);
    sys_rst = 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      // all-dominant word first: longest dominant run a frame allows
      data = i ? 16'($urandom) : 16'h0;
      frame();
      cyc(8);
      chk("st", 5'h07, st);
    end
    loop = 1'b0;
    e = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      {set_pair, bus_open} = pat[i];
      e = exp_rx(pat[i], e);
      cyc(5);
      chk("st", {3'h1, e, 1'b1}, st);
    end
    stuck = 1'b1;
    cyc(tc - 5);
    chk("timeout", 5'h0f, st);
    cyc(15);
    chk("st", 5'h16, st);
    {set_pair, bus_open} = 3'h4;
    cyc(5);
    chk("st", 5'h14, st);
    stuck = 1'b0;
    cyc(8);
    chk("st", 5'h05, st);
    {thermal_shutdown, stuck, set_pair} = 4'hd;
    cyc(8);
    chk("st", 5'h06, st);
    stuck = 1'b0;
    cyc(4);
    thermal_shutdown = 1'b0;
    cyc(6);
    chk("st", 5'h07, st);
    {bus_side_supply_low, set_pair} = 3'h6;
    cyc(6);
    chk("st", 5'h02, st);
    {bus_side_supply_low, set_pair} = 3'h1;
    cyc(5);
    chk("enabled", 5'h0, {4'h0, driver_enabled});
    cyc(uc + 5);
    chk("st", 5'h07, st);
    report_and_stop();
  end
endmodule : can_phy_dominant_timeout_guard_tb_top
`default_nettype wire
